//--- pgcs_host_model.sv
// serial host model with a pulled-up data line
`timescale 1ns/1ps
`default_nettype none
module pgcs_host_model (
  input wire logic core_clk,
  input wire logic sda_oe,
  output logic scl,
  output wire logic sda
);
  logic drv = 1'b1;
  logic rd_stb = 1'b0;
  logic [7:0] rd_byte;
  initial scl = 1'b1;
  assign sda = drv & ~sda_oe;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic bitx(input logic b, output logic r);
    drv <= b;
    tick(3);
    scl <= 1'b1;
    tick(3);
    r = sda;
    scl <= 1'b0;
    tick(2);
  endtask : bitx
  task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx, output logic nak);
    for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
    bitx(1'b1, nak);
  endtask : byte_x
  task automatic start;
    drv <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(3);
    drv <= 1'b0;
    tick(3);
    scl <= 1'b0;
    tick(2);
  endtask : start
  task automatic stop;
    drv <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(3);
    drv <= 1'b1;
    tick(3);
  endtask : stop
  task automatic wr(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d, output logic nak);
    logic [7:0] rx;
    logic n0, n1;
    start();
    byte_x({dev, 1'b0}, rx, n0);
    byte_x(p, rx, n1);
    byte_x(d, rx, nak);
    stop();
    nak = nak | n0 | n1;
  endtask : wr
  task automatic rd(input logic [6:0] dev, input logic [7:0] p);
    logic [7:0] rx;
    logic n;
    start();
    byte_x({dev, 1'b0}, rx, n);
    byte_x(p, rx, n);
    start();
    byte_x({dev, 1'b1}, rx, n);
    byte_x(8'hFF, rd_byte, n);
    stop();
    rd_stb <= 1'b1;
    tick(1);
    rd_stb <= 1'b0;
  endtask : rd
endmodule : pgcs_host_model
`default_nettype wire

//--- pgcs_pin_cell.sv
// one port pin: pad drive, pull-down control and polarity-adjusted input
`timescale 1ns/1ps
`default_nettype none
module pgcs_pin_cell (
  input wire logic [1:0] code,
  input wire logic invert,
  input wire logic drive,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pulldown_en,
  output logic func_level,
  output logic reg_level
);

  logic adj;

  always_comb begin
    adj = pad_in ^ invert;
    pad_out = drive;
    pad_oe = (code == pgcs_pkg::CODE_OUTPUT);
    pulldown_en = (code == pgcs_pkg::CODE_UNCONF);
    func_level = (code == pgcs_pkg::CODE_FUNC) ? adj : 1'b0;
    reg_level = (code == pgcs_pkg::CODE_REG_EN) ? adj : 1'b0;
  end

endmodule : pgcs_pin_cell
`default_nettype wire

//--- pgcs_pkg.sv
// shared constants, state and carrier types of the pin port and conversion status block
package pgcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets and reset values
  localparam logic [7:0] FUNC_SEL_ADDR = 8'h5D;
  localparam logic [7:0] INV_DRIVE_ADDR = 8'h5E;
  localparam logic [7:0] CONV_STATUS_ADDR = 8'h9A;
  localparam logic [7:0] SYS_STATUS_FIRST_ADDR = 8'hB9;
  localparam logic [7:0] CONV_UNIT_STATUS_ADDR = 8'hBC;
  localparam logic [7:0] FUNC_SEL_RESET = 8'h00;
  localparam logic [7:0] INV_DRIVE_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // field layout
  localparam int NUM_PINS = 4;
  localparam int CODE_W = 2;
  localparam int INV_LSB = 4;
  localparam int DRIVE_LSB = 0;
  localparam int PIN1 = 0;
  localparam int PIN2 = 1;
  localparam int PIN3 = 2;
  localparam int PIN4 = 3;
  localparam int CS_DONE = 7;
  localparam int CS_FAULT = 6;
  localparam int CS_UPPER = 5;
  localparam int CS_LOWER = 4;
  localparam int CS_PIN4 = 1;
  localparam int CS_PIN2 = 0;
  localparam int CU_BUSY = 4;
  localparam int CU_IRQ = 0;

  ////////////////////////////////////////////////////////////////////////////
  // pin function codes
  localparam logic [1:0] CODE_UNCONF = 2'h0;
  localparam logic [1:0] CODE_OUTPUT = 2'h1;
  localparam logic [1:0] CODE_FUNC = 2'h2;
  localparam logic [1:0] CODE_REG_EN = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // serial host port
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2D; // arbitrary value
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [7:0] PTR_STEP = 8'h01;

  typedef enum logic [7:0] {
    PGCS_IDLE = 8'h01,
    PGCS_ADDR = 8'h02,
    PGCS_ACK_ADDR = 8'h04,
    PGCS_PTR = 8'h08,
    PGCS_WRITE = 8'h10,
    PGCS_ACK_RX = 8'h20,
    PGCS_READ = 8'h40,
    PGCS_MACK = 8'h80
  } pgcs_state_e;

  typedef struct packed {
    logic eoc;
    logic busy;
    logic fault;
    logic upper;
    logic lower;
  } pgcs_conv_s;

  typedef struct packed {
    logic trig_pin4;
    logic trig_pin2;
    logic pwm_mode;
    logic reg_en_c;
    logic reg_en_b;
    logic reg_en_a;
  } pgcs_func_s;

  typedef struct packed {
    pgcs_state_e state;
    logic [7:0] func_sel;
    logic [7:0] inv_drive;
    logic conv_fault;
    logic upper_fault;
    logic lower_fault;
    logic pin4_end;
    logic pin2_end;
    logic irq_flag;
    logic scl_q;
    logic sda_q;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [7:0] ptr;
    logic rw;
    logic sda_drive;
    logic master_ack;
  } pgcs_state_s;

endpackage : pgcs_pkg

//--- pgcs_top.sv
// pin port, conversion status and serial register access of the power unit
`timescale 1ns/1ps
`default_nettype none
// Operation
// - four pins, two-bit code each, pin4 high
// - code 00: pin undriven, pull-down on
// - code 01: drive pin from drive bit
// - input pins pass through invert bit
// - code 10: triggers, mode control, pin3 unused
// - code 11: regulator group enables, pin1 unused
// - reset clears function select register
// - status registers read only to host
// - conversion status done, fault, limit bits
// - capture pin4, pin2 levels at end
// - reading conversion status clears converter flag
module pgcs_top #(
  parameter logic [6:0] DEV_ADDR = pgcs_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [3:0] pad_in,
  output logic [3:0] pad_out,
  output logic [3:0] pad_oe,
  output logic [3:0] pulldown_en,
  input wire pgcs_pkg::pgcs_conv_s conv,
  input wire logic [7:0] sys_status_first_in,
  output var pgcs_pkg::pgcs_func_s func,
  output logic converter_irq_flag
);

  //////////////////////////////////////////////////////////////////////////////
  // register read view

  function automatic logic [7:0] pgcs_read(
    input pgcs_pkg::pgcs_state_s s,
    input logic [7:0] addr,
    input logic [7:0] system_status_first,
    input logic busy
  );
    logic [7:0] v;
    v = pgcs_pkg::READ_UNMAPPED;
    unique case (addr)
      pgcs_pkg::FUNC_SEL_ADDR: v = s.func_sel;
      pgcs_pkg::INV_DRIVE_ADDR: v = s.inv_drive;
      pgcs_pkg::CONV_STATUS_ADDR: begin
        v[pgcs_pkg::CS_DONE] = ~busy;
        v[pgcs_pkg::CS_FAULT] = s.conv_fault;
        v[pgcs_pkg::CS_UPPER] = s.upper_fault;
        v[pgcs_pkg::CS_LOWER] = s.lower_fault;
        v[pgcs_pkg::CS_PIN4] = s.pin4_end;
        v[pgcs_pkg::CS_PIN2] = s.pin2_end;
      end
      pgcs_pkg::SYS_STATUS_FIRST_ADDR: v = system_status_first;
      pgcs_pkg::CONV_UNIT_STATUS_ADDR: begin
        v[pgcs_pkg::CU_BUSY] = busy;
        v[pgcs_pkg::CU_IRQ] = s.irq_flag;
      end
      default: v = pgcs_pkg::READ_UNMAPPED;
    endcase
    return v;
  endfunction : pgcs_read

  //////////////////////////////////////////////////////////////////////////////
  // next-state helpers

  // pointer and bit counter steps
  function automatic logic [7:0] pgcs_ptr_step(input logic [7:0] ptr);
    return ptr + pgcs_pkg::PTR_STEP;
  endfunction : pgcs_ptr_step

  function automatic logic [3:0] pgcs_cnt_step(input logic [3:0] cnt);
    return cnt + pgcs_pkg::CNT_ONE;
  endfunction : pgcs_cnt_step

  // end-of-conversion capture
  function automatic pgcs_pkg::pgcs_state_s pgcs_capture(
    input pgcs_pkg::pgcs_state_s s,
    input pgcs_pkg::pgcs_conv_s cv,
    input logic [3:0] pins
  );
    pgcs_pkg::pgcs_state_s n;
    n = s;
    n.conv_fault = cv.fault;
    n.upper_fault = cv.upper;
    n.lower_fault = cv.lower;
    n.pin4_end = pins[pgcs_pkg::PIN4];
    n.pin2_end = pins[pgcs_pkg::PIN2];
    return n;
  endfunction : pgcs_capture

  // first bit of a read byte, no stale host ack
  function automatic pgcs_pkg::pgcs_state_s pgcs_load_read(
    input pgcs_pkg::pgcs_state_s s,
    input logic [7:0] rd_val
  );
    pgcs_pkg::pgcs_state_s n;
    n = s;
    n.shift = rd_val;
    n.sda_drive = ~rd_val[7];
    n.bit_cnt = pgcs_pkg::CNT_ZERO;
    n.master_ack = 1'b0;
    n.ptr = pgcs_ptr_step(s.ptr);
    n.state = pgcs_pkg::PGCS_READ;
    return n;
  endfunction : pgcs_load_read

  // register write by pointer, read-only offsets ignored
  function automatic pgcs_pkg::pgcs_state_s pgcs_store(
    input pgcs_pkg::pgcs_state_s s,
    input logic [7:0] wr_val
  );
    pgcs_pkg::pgcs_state_s n;
    n = s;
    unique case (s.ptr)
      pgcs_pkg::FUNC_SEL_ADDR: n.func_sel = wr_val;
      pgcs_pkg::INV_DRIVE_ADDR: n.inv_drive = wr_val;
      default: n.func_sel = s.func_sel;
    endcase
    n.ptr = pgcs_ptr_step(s.ptr);
    return n;
  endfunction : pgcs_store

  //////////////////////////////////////////////////////////////////////////////
  // pin cells

  pgcs_pkg::pgcs_state_s r;
  pgcs_pkg::pgcs_state_s next_r;
  logic [3:0] func_level;
  logic [3:0] reg_level;

  genvar gi;
  generate
    for (gi = 0; gi < pgcs_pkg::NUM_PINS; gi++) begin : g_pin
      pgcs_pin_cell u_cell (
        .code(r.func_sel[gi*pgcs_pkg::CODE_W +: pgcs_pkg::CODE_W]),
        .invert(r.inv_drive[pgcs_pkg::INV_LSB + gi]),
        .drive(r.inv_drive[pgcs_pkg::DRIVE_LSB + gi]),
        .pad_in(pad_in[gi]),
        .pad_out(pad_out[gi]),
        .pad_oe(pad_oe[gi]),
        .pulldown_en(pulldown_en[gi]),
        .func_level(func_level[gi]),
        .reg_level(reg_level[gi])
      );
    end
  endgenerate

  always_comb begin
    func.trig_pin4 = func_level[pgcs_pkg::PIN4];
    func.trig_pin2 = func_level[pgcs_pkg::PIN2];
    func.pwm_mode = func_level[pgcs_pkg::PIN1];
    func.reg_en_c = reg_level[pgcs_pkg::PIN4];
    func.reg_en_b = reg_level[pgcs_pkg::PIN3];
    func.reg_en_a = reg_level[pgcs_pkg::PIN2];
  end

  assign sda_out = 1'b0;
  assign sda_oe = r.sda_drive;
  assign converter_irq_flag = r.irq_flag;

  //////////////////////////////////////////////////////////////////////////////
  // next state

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic status_read;
  logic [7:0] rd_byte;

  always_comb begin
    next_r = r;
    scl_rise = scl_in & ~r.scl_q;
    scl_fall = ~scl_in & r.scl_q;
    start_cond = scl_in & r.scl_q & r.sda_q & ~sda_in;
    stop_cond = scl_in & r.scl_q & ~r.sda_q & sda_in;
    status_read = 1'b0;
    rd_byte = pgcs_read(r, r.ptr, sys_status_first_in, conv.busy);
    next_r.scl_q = scl_in;
    next_r.sda_q = sda_in;

    if (conv.eoc) begin
      next_r = pgcs_capture(next_r, conv, pad_in);
    end

    if (start_cond) begin
      next_r.state = pgcs_pkg::PGCS_ADDR;
      next_r.bit_cnt = pgcs_pkg::CNT_ZERO;
      next_r.sda_drive = 1'b0;
    end else if (stop_cond) begin
      next_r.state = pgcs_pkg::PGCS_IDLE;
      next_r.sda_drive = 1'b0;
    end else begin
      unique case (r.state)
        pgcs_pkg::PGCS_IDLE: next_r.sda_drive = 1'b0;
        pgcs_pkg::PGCS_ADDR, pgcs_pkg::PGCS_PTR, pgcs_pkg::PGCS_WRITE: begin
          if (scl_rise) begin
            next_r.shift = {r.shift[6:0], sda_in};
            next_r.bit_cnt = pgcs_cnt_step(r.bit_cnt);
          end else if (scl_fall && r.bit_cnt == pgcs_pkg::BYTE_BITS) begin
            next_r.bit_cnt = pgcs_pkg::CNT_ZERO;
            next_r.sda_drive = 1'b1;
            next_r.state = pgcs_pkg::PGCS_ACK_RX;
            if (r.state == pgcs_pkg::PGCS_ADDR) begin
              next_r.rw = r.shift[0];
              next_r.state = pgcs_pkg::PGCS_ACK_ADDR;
              if (r.shift[7:1] != DEV_ADDR) begin
                next_r.sda_drive = 1'b0;
                next_r.state = pgcs_pkg::PGCS_IDLE;
              end
            end else if (r.state == pgcs_pkg::PGCS_PTR) begin
              next_r.ptr = r.shift;
            end else begin
              next_r = pgcs_store(next_r, r.shift);
            end
          end
        end
        pgcs_pkg::PGCS_ACK_ADDR: begin
          if (scl_fall) begin
            if (r.rw) begin
              next_r = pgcs_load_read(next_r, rd_byte);
              status_read = 1'b1;
            end else begin
              next_r.sda_drive = 1'b0;
              next_r.state = pgcs_pkg::PGCS_PTR;
            end
          end
        end
        pgcs_pkg::PGCS_ACK_RX: begin
          if (scl_fall) begin
            next_r.sda_drive = 1'b0;
            next_r.state = pgcs_pkg::PGCS_WRITE;
          end
        end
        pgcs_pkg::PGCS_READ: begin
          if (scl_fall) begin
            if (r.bit_cnt == pgcs_pkg::LAST_TX_BIT) begin
              next_r.sda_drive = 1'b0;
              next_r.bit_cnt = pgcs_pkg::CNT_ZERO;
              next_r.state = pgcs_pkg::PGCS_MACK;
            end else begin
              next_r.shift = {r.shift[6:0], 1'b0};
              next_r.sda_drive = ~r.shift[6];
              next_r.bit_cnt = pgcs_cnt_step(r.bit_cnt);
            end
          end
        end
        pgcs_pkg::PGCS_MACK: begin
          if (scl_rise) begin
            next_r.master_ack = ~sda_in;
          end else if (scl_fall) begin
            if (r.master_ack) begin
              next_r = pgcs_load_read(next_r, rd_byte);
              status_read = 1'b1;
            end else begin
              next_r.state = pgcs_pkg::PGCS_IDLE;
            end
          end
        end
      endcase
    end

    if (status_read && r.ptr == pgcs_pkg::CONV_STATUS_ADDR) begin
      next_r.irq_flag = 1'b0;
    end
    if (conv.eoc) begin
      next_r.irq_flag = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r.state <= pgcs_pkg::PGCS_IDLE;
      r.func_sel <= pgcs_pkg::FUNC_SEL_RESET;
      r.inv_drive <= pgcs_pkg::INV_DRIVE_RESET;
      r.conv_fault <= 1'b0;
      r.upper_fault <= 1'b0;
      r.lower_fault <= 1'b0;
      r.pin4_end <= 1'b0;
      r.pin2_end <= 1'b0;
      r.irq_flag <= 1'b0;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
      r.shift <= 8'h00;
      r.bit_cnt <= pgcs_pkg::CNT_ZERO;
      r.ptr <= 8'h00;
      r.rw <= 1'b0;
      r.sda_drive <= 1'b0;
      r.master_ack <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

endmodule : pgcs_top
`default_nettype wire

//--- pgcs_top_assertions.sv
// concurrent checks on the ports of the pin port and conversion status block
`timescale 1ns/1ps
`default_nettype none
module pgcs_top_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic [3:0] pad_oe,
  input wire logic [3:0] pulldown_en,
  input wire pgcs_pkg::pgcs_conv_s conv,
  input wire pgcs_pkg::pgcs_func_s func,
  input wire logic converter_irq_flag
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  oe_pd_excl_a: assert property ((pad_oe & pulldown_en) == 4'h0)
    else $error("pin both driven and pulled down");
  pd_func4_a: assert property (pulldown_en[3] |-> !func.trig_pin4 && !func.reg_en_c)
    else $error("idle pin4 feeds a function");
  oe_func2_a: assert property (pad_oe[1] |-> !func.trig_pin2 && !func.reg_en_a)
    else $error("output pin2 feeds a function");
  pd_func1_a: assert property (pulldown_en[0] |-> !func.pwm_mode)
    else $error("idle pin1 feeds mode control");
  reg_b_role_a: assert property (func.reg_en_b |-> !pad_oe[2] && !pulldown_en[2])
    else $error("group b enable from a non input pin");
  reset_state_a: assert property ($fell(rst) |-> pad_oe == 4'h0 && pulldown_en == 4'hF)
    else $error("pins not unconfigured after reset");
  eoc_irq_a: assert property (conv.eoc |=> converter_irq_flag)
    else $error("end of conversion did not raise flag");
  irq_clear_a: assert property ($fell(converter_irq_flag) |-> !$past(scl_in) && $past(scl_in, 2))
    else $error("flag cleared outside a byte load");
  cover property (conv.eoc);
  cover property ($fell(converter_irq_flag));
  cover property (func.reg_en_b);
endmodule : pgcs_top_assertions
bind pgcs_top pgcs_top_assertions u_chk (.core_clk(core_clk), .rst(rst), .scl_in(scl_in), .pad_oe(pad_oe),
  .pulldown_en(pulldown_en), .conv(conv), .func(func), .converter_irq_flag(converter_irq_flag));
`default_nettype wire

//--- test_pmu_gpio_and_conversion_status.sv
// self-checking bench of the pin port and conversion status block
`timescale 1ns/1ps
`default_nettype none
module test_pmu_gpio_and_conversion_status;
  localparam logic [6:0] A = pgcs_pkg::DEV_ADDR_DEFAULT;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] pad_in = 4'h0;
  pgcs_pkg::pgcs_conv_s conv = '0;
  logic [7:0] sys_in = 8'h00;
  logic scl, sda, sda_out, sda_oe, irq, ack, bz;
  logic [3:0] pad_out, pad_oe, pd, pi;
  pgcs_pkg::pgcs_func_s func;
  logic [7:0] fs, iv, e9, sv, exp_q[$];
  logic [2:0] cv;
  int n_fail = 0;
  int checked = 0;
  always #50 core_clk = ~core_clk;
  pgcs_top uut (.core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pulldown_en(pd), .conv(conv),
    .sys_status_first_in(sys_in), .func(func), .converter_irq_flag(irq));
  pgcs_host_model host (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d fails %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(A, a);
  endtask : rd
  task automatic pins;
    logic [3:0] l;
    l = pad_in ^ iv[7:4];
    chk({2'h0, func}, {2'h0, (fs[7:6] == 2'h2) & l[3], (fs[3:2] == 2'h2) & l[1], (fs[1:0] == 2'h2) & l[0],
      (fs[7:6] == 2'h3) & l[3], (fs[5:4] == 2'h3) & l[2], (fs[3:2] == 2'h3) & l[1]});
    for (int i = 0; i < 4; i++) begin
      chk({7'h0, pad_oe[i]}, {7'h0, fs[2*i+:2] == 2'h1});
      chk({7'h0, pd[i]}, {7'h0, fs[2*i+:2] == 2'h0});
    end
    chk({4'h0, pad_out}, {4'h0, iv[3:0]});
    chk({7'h0, sda_out}, 8'h00);
  endtask : pins
  always @(posedge core_clk) begin
    if (host.rd_stb === 1'b1) chk(host.rd_byte, exp_q.pop_front());
  end
  initial begin
    repeat (50000) @(posedge core_clk);
    n_fail++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hB79B));
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    fs = 8'h00;
    iv = 8'h00;
    pins();
    rd(8'h5D, 8'h00);
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      fs = (k < 4) ? {4{k[1:0]}} : 8'($urandom);
      iv = 8'($urandom);
      host.wr(A, 8'h5D, fs, ack);
      host.wr(A, 8'h5E, iv, ack);
      pad_in <= 4'($urandom);
      repeat (2) @(posedge core_clk);
      pins();
      rd(8'h5D, fs);
    end
    $display("pin mode test done");
    host.wr(A, 8'h5D, 8'h00, ack);
    for (int k = 0; k < 3; k++) begin
      cv = 3'($urandom);
      pi = 4'($urandom);
      bz = k[0];
      pad_in <= pi;
      conv <= {1'b1, bz, cv};
      @(posedge core_clk);
      conv.eoc <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk({7'h0, irq}, 8'h01);
      rd(8'hBC, {3'h0, bz, 3'h0, 1'b1});
      e9 = {~bz, cv, 2'h0, pi[3], pi[1]};
      rd(8'h9A, e9);
      chk({7'h0, irq}, 8'h00);
    end
    $display("conversion test done");
    sv = 8'($urandom);
    sys_in <= sv;
    host.wr(A, 8'hB9, ~sv, ack);
    host.wr(A, 8'h9A, ~e9, ack);
    rd(8'hB9, sv);
    rd(8'h9A, e9);
    rd(8'h40, 8'h00);
    host.wr(A ^ 7'h01, 8'h5D, 8'h55, ack);
    chk({7'h0, ack}, 8'h01);
    rd(8'h5D, 8'h00);
    $display("read only test done");
    give_verdict();
  end
endmodule : test_pmu_gpio_and_conversion_status
`default_nettype wire
